// ==== common/tcio_pkg.sv ====
package tcio_pkg;

  // ----------------------------------------
  // Register map and field positions
  // ----------------------------------------
  localparam int unsigned ADDR_W = 12;
  localparam int unsigned CNT_W_DEF = 16;
  localparam int unsigned CHANNEL_DEF = 2;
  localparam logic [11:0] OFS_IOCTL = 12'h000;
  localparam logic [11:0] OFS_INTEN = 12'h004;
  localparam logic [11:0] OFS_STAT = 12'h008;
  localparam logic [11:0] OFS_REGB = 12'h00C;
  localparam logic [11:0] OFS_CNT = 12'h010;
  localparam int unsigned IOC_LSB = 4;
  localparam int unsigned EN_ADC_BIT = 6;
  localparam int unsigned EN_UDF_BIT = 5;
  localparam int unsigned EN_OVF_BIT = 4;
  localparam int unsigned EN_REGD_BIT = 3;
  localparam int unsigned EN_REGB_BIT = 1;
  localparam logic [3:0] IOC_RST = 4'h0;
  localparam logic [7:0] EN_RST = 8'h00;
  localparam logic [7:0] STAT_RST = 8'h00;

  // ----------------------------------------
  // Types
  // ----------------------------------------
  typedef enum logic [1:0] {
    ACT_KEEP = 2'b00,
    ACT_LOW = 2'b01,
    ACT_HIGH = 2'b10,
    ACT_TOGGLE = 2'b11
  } tcio_act_t;

  typedef struct packed {
    logic capture;
    logic init_level;
    tcio_act_t act;
  } tcio_ioc_t;

  typedef struct packed {
    logic trough;
    logic underflow;
    logic overflow;
    logic reg_d;
  } tcio_evt_t;

  // Enable bits that exist in a given channel
  function automatic logic [7:0] tcio_en_mask(input int unsigned ch);
    logic [7:0] m;
    m = 8'h00;
    m[EN_REGB_BIT] = 1'b1;
    m[EN_OVF_BIT] = 1'b1;
    m[EN_ADC_BIT] = (ch == 4);
    m[EN_UDF_BIT] = (ch == 1) || (ch == 2);
    m[EN_REGD_BIT] = (ch == 0) || (ch == 3) || (ch == 4);
    return m;
  endfunction : tcio_en_mask

endpackage : tcio_pkg

// ==== rtl/tcio_pin_unit.sv ====
`timescale 1ns/1ps
module tcio_pin_unit
  import tcio_pkg::*;
(
  input wire logic clk_in,
  input wire logic arst_n_in,
  input wire tcio_ioc_t ioc_in,
  input wire logic ioc_upd_in,
  input wire logic match_in,
  input wire logic pin_in,
  output logic pin_out,
  output logic pin_oe_out,
  output logic capture_out
);

  logic pin_q;
  logic pin_d;
  logic prev_q;
  wire logic rise;
  wire logic fall;
  wire logic edge_hit;
  wire logic oc_mode;

  assign oc_mode = ~ioc_in.capture;
  assign rise = pin_in & ~prev_q;
  assign fall = ~pin_in & prev_q;

  // ----------------------------------------
  // Capture edge select
  // ----------------------------------------
  assign edge_hit = ioc_in.act[1] ? (rise | fall) :
                    ioc_in.act[0] ? fall :
                    rise;
  assign capture_out = ioc_in.capture & edge_hit;

  // ----------------------------------------
  // Compare output level
  // ----------------------------------------
  always_comb begin
    pin_d = pin_q;
    if (ioc_upd_in && oc_mode && ioc_in.act != ACT_KEEP) begin
      pin_d = ioc_in.init_level;
    end else if (match_in && oc_mode) begin
      case (ioc_in.act)
        ACT_LOW: pin_d = 1'b0;
        ACT_HIGH: pin_d = 1'b1;
        ACT_TOGGLE: pin_d = ~pin_q;
        default: pin_d = pin_q;
      endcase
    end
  end

  // Low from reset until software programs the pin
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      pin_q <= 1'b0;
      prev_q <= 1'b0;
    end else begin
      pin_q <= pin_d;
      prev_q <= pin_in;
    end
  end

  assign pin_out = pin_q;
  assign pin_oe_out = oc_mode;

endmodule : tcio_pin_unit

// ==== rtl/tcio_top.sv ====
// Operation
// - Output compare with action code 01 drives the pin low on each match.
// - Output compare with action code 10 drives the pin high on each match.
// - Output compare with action code 11 inverts the pin on each match.
// - Capture mode with code 00 captures on a rising pin edge, bit 6 ignored.
// - Capture mode with code 01 captures on a falling pin edge.
// - Capture mode with bit 5 set captures on both edges, bit 4 ignored.
// - After reset the pin is driven low until the control register is first written.
// - Enable bit 6 gates converter start requests from the channel 4 trough in complementary PWM.
// - Enable bit 6 reads zero in channels 0 to 3 and software writes zero there.
// - Enable bit 5 gates the underflow request in channels 1 and 2.
// - Enable bit 5 reads zero in channels 0, 3 and 4 and software writes zero there.
// - Enable bit 4 gates the overflow request.
// - Enable bit 3 gates the register D request in channels 0, 3 and 4.
// - Enable bit 3 reads zero in channels 1 and 2 and software writes zero there.
//
// Local design decisions: the placing of the registers and the APB interface to the registers.
`timescale 1ns/1ps
module tcio_top
  import tcio_pkg::*;
#(
  parameter int unsigned CHANNEL = CHANNEL_DEF,
  parameter int unsigned CNT_W = CNT_W_DEF
) (
  input wire logic clk_in,
  input wire logic arst_n_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [ADDR_W-1:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  input wire logic [3:0] pstrb_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  input wire logic [CNT_W-1:0] counter_in,
  input wire tcio_evt_t evt_in,
  input wire logic comp_pwm_in,
  input wire logic pin_in,
  output logic pin_out,
  output logic pin_oe_out,
  output logic irq_out,
  output logic udf_irq_out,
  output logic ovf_irq_out,
  output logic regd_irq_out,
  output logic adc_start_out
);

  // ----------------------------------------
  // Elaboration checks
  // ----------------------------------------
  if (CHANNEL > 4 || CNT_W < 2 || CNT_W > 16) begin : g_bad_param
    $error("tcio_top: CHANNEL must be 0..4 and CNT_W 2..16");
  end

  localparam logic [7:0] EN_MASK = tcio_en_mask(CHANNEL);
  localparam logic [7:0] ST_MASK = EN_MASK & ~(8'h01 << EN_ADC_BIT);

  // Address decode for the error answer; the read mux compares paddr_in on its own
  function automatic logic tcio_hit(input logic [ADDR_W-1:0] a);
    return (a == OFS_IOCTL) || (a == OFS_INTEN) || (a == OFS_STAT) ||
           (a == OFS_REGB) || (a == OFS_CNT);
  endfunction : tcio_hit

  // ----------------------------------------
  // State
  // ----------------------------------------
  tcio_ioc_t ioc_q;
  tcio_ioc_t ioc_d;
  logic [7:0] en_q;
  logic [7:0] en_d;
  logic [7:0] st_q;
  logic [7:0] st_d;
  logic [CNT_W-1:0] regb_q;
  logic [CNT_W-1:0] regb_d;
  logic ioc_upd_q;
  logic ioc_written_q;
  logic eq_q;
  logic adc_q;
  logic [31:0] rdata_q;
  logic err_q;

  // ----------------------------------------
  // APB decode
  // ----------------------------------------
  wire logic setup;
  wire logic wr;
  wire logic wr_ioc;
  wire logic wr_en;
  wire logic wr_st;
  wire logic wr_regb;
  wire logic [15:0] regb_ext;
  wire logic [15:0] regb_wr;
  wire logic [31:0] rdata;
  wire logic [7:0] st_set;
  wire logic [7:0] st_clr;
  wire logic [7:0] st_act;
  wire logic eq;
  wire logic oc_mode;
  wire logic match;
  wire logic cap_pulse;

  assign setup = psel_in & ~penable_in;
  assign wr = psel_in & penable_in & pwrite_in;
  assign wr_ioc = wr & (paddr_in == OFS_IOCTL) & pstrb_in[0];
  assign wr_en = wr & (paddr_in == OFS_INTEN) & pstrb_in[0];
  assign wr_st = wr & (paddr_in == OFS_STAT) & pstrb_in[0];
  assign wr_regb = wr & (paddr_in == OFS_REGB);

  // Lane merge on a 16-bit view, so a narrow counter needs no special case
  assign regb_ext = 16'(regb_q);
  assign regb_wr = {pstrb_in[1] ? pwdata_in[15:8] : regb_ext[15:8], pstrb_in[0] ? pwdata_in[7:0] : regb_ext[7:0]};

  // Reserved enable and status bits never store a one
  assign rdata = (paddr_in == OFS_IOCTL) ? {24'h000000, ioc_q, 4'h0} :
                 (paddr_in == OFS_INTEN) ? {24'h000000, en_q} :
                 (paddr_in == OFS_STAT) ? {24'h000000, st_q} :
                 (paddr_in == OFS_REGB) ? 32'(regb_q) :
                 (paddr_in == OFS_CNT) ? 32'(counter_in) :
                 32'h00000000;

  // Zero wait state; read data is sampled in the setup cycle
  assign pready_out = psel_in & penable_in;
  assign prdata_out = rdata_q;
  assign pslverr_out = err_q;

  // ----------------------------------------
  // Compare match and capture
  // ----------------------------------------
  // Match on the first cycle of equality, so a slow counter matches once
  assign oc_mode = ~ioc_q.capture;
  assign eq = (counter_in == regb_q);
  assign match = eq & ~eq_q & oc_mode;

  tcio_pin_unit u_pin (
    .clk_in(clk_in),
    .arst_n_in(arst_n_in),
    .ioc_in(ioc_q),
    .ioc_upd_in(ioc_upd_q),
    .match_in(match),
    .pin_in(pin_in),
    .pin_out(pin_out),
    .pin_oe_out(pin_oe_out),
    .capture_out(cap_pulse)
  );

  // ----------------------------------------
  // Register next values
  // ----------------------------------------
  assign st_set = {2'b00, evt_in.underflow, evt_in.overflow, evt_in.reg_d, 1'b0, match | cap_pulse, 1'b0};
  assign st_clr = wr_st ? pwdata_in[7:0] : 8'h00;

  always_comb begin
    ioc_d = wr_ioc ? tcio_ioc_t'(pwdata_in[7:IOC_LSB]) : ioc_q;
    en_d = wr_en ? (pwdata_in[7:0] & EN_MASK) : en_q;
    st_d = ((st_q & ~st_clr) | st_set) & ST_MASK;
    regb_d = wr_regb ? regb_wr[CNT_W-1:0] : regb_q;
    // Hardware capture outranks a software write in the same cycle
    if (cap_pulse) begin
      regb_d = counter_in;
    end
  end

  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      ioc_q <= tcio_ioc_t'(IOC_RST);
      en_q <= EN_RST;
      st_q <= STAT_RST;
      regb_q <= '0;
    end else begin
      ioc_q <= ioc_d;
      en_q <= en_d;
      st_q <= st_d;
      regb_q <= regb_d;
    end
  end

  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      ioc_upd_q <= 1'b0;
      ioc_written_q <= 1'b0;
      eq_q <= 1'b0;
      adc_q <= 1'b0;
    end else begin
      ioc_upd_q <= wr_ioc;
      ioc_written_q <= ioc_written_q | wr_ioc;
      eq_q <= eq;
      adc_q <= evt_in.trough & comp_pwm_in & en_q[EN_ADC_BIT];
    end
  end

  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      rdata_q <= 32'h00000000;
      err_q <= 1'b0;
    end else if (setup) begin
      rdata_q <= pwrite_in ? 32'h00000000 : rdata;
      err_q <= ~tcio_hit(paddr_in);
    end
  end

  // ----------------------------------------
  // Interrupt requests
  // ----------------------------------------
  assign st_act = st_q & en_q;
  assign udf_irq_out = st_act[EN_UDF_BIT];
  assign ovf_irq_out = st_act[EN_OVF_BIT];
  assign regd_irq_out = st_act[EN_REGD_BIT];
  assign irq_out = |st_act;
  assign adc_start_out = adc_q;

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!arst_n_in);

  match_low_a : assert property (
    match && ioc_q.act == ACT_LOW && !ioc_upd_q |=> !pin_out && pin_oe_out
  ) else $error("pin not low after match");

  match_high_a : assert property (
    match && ioc_q.act == ACT_HIGH && !ioc_upd_q |=> pin_out
  ) else $error("pin not high after match");

  match_toggle_a : assert property (
    match && ioc_q.act == ACT_TOGGLE && !ioc_upd_q |=> pin_out != $past(pin_out)
  ) else $error("pin not inverted after match");

  init_level_a : assert property (
    ioc_upd_q && oc_mode && ioc_q.act != ACT_KEEP |=> pin_out == $past(ioc_q.init_level)
  ) else $error("initial level not applied");

  keep_level_a : assert property (
    oc_mode && ioc_q.act == ACT_KEEP ##1 oc_mode && ioc_q.act == ACT_KEEP |-> $stable(pin_out)
  ) else $error("retained output moved");

  cap_rise_a : assert property (
    ioc_q.capture && ioc_q.act == ACT_KEEP && $rose(pin_in) |-> cap_pulse
  ) else $error("rising edge not captured");

  cap_fall_a : assert property (
    ioc_q.capture && ioc_q.act == ACT_LOW && $fell(pin_in) |-> cap_pulse
  ) else $error("falling edge not captured");

  cap_both_a : assert property (
    ioc_q.capture && ioc_q.act[1] && $changed(pin_in) |-> cap_pulse
  ) else $error("edge missed in both-edge mode");

  reset_low_a : assert property (
    !ioc_written_q |-> pin_oe_out && !pin_out
  ) else $error("pin not held low before setup");

  adc_gate_a : assert property (
    evt_in.trough && comp_pwm_in |=> adc_start_out == $past(en_q[EN_ADC_BIT])
  ) else $error("converter start not gated");

  reserved_zero_a : assert property (
    (en_q & ~EN_MASK) == 8'h00 && (st_q & ~ST_MASK) == 8'h00
  ) else $error("reserved bit set");

  udf_irq_a : assert property (
    evt_in.underflow && en_q[EN_UDF_BIT] && !wr_en |=> udf_irq_out
  ) else $error("underflow request missing");

  ovf_irq_a : assert property (
    !en_q[EN_OVF_BIT] |-> !ovf_irq_out
  ) else $error("overflow request not gated");

  ovf_set_a : assert property (
    evt_in.overflow && en_q[EN_OVF_BIT] && !wr_en |=> ovf_irq_out
  ) else $error("overflow request missing");

  regd_irq_a : assert property (
    evt_in.reg_d && en_q[EN_REGD_BIT] && !wr_en |=> regd_irq_out
  ) else $error("register D request missing");

  capture_copy_a : assert property (
    cap_pulse |=> regb_q == $past(counter_in) && st_q[EN_REGB_BIT]
  ) else $error("capture value or flag wrong");

  match_flag_a : assert property (
    match |=> st_q[EN_REGB_BIT]
  ) else $error("match flag not set");

  oc_drive_a : assert property (
    !ioc_q.capture |-> pin_oe_out
  ) else $error("pin not driven in compare mode");

  cap_release_a : assert property (
    ioc_q.capture |-> !pin_oe_out
  ) else $error("pin driven in capture mode");

  cap_no_match_a : assert property (
    ioc_q.capture |-> !match
  ) else $error("match raised in capture mode");

  match_once_a : assert property (
    match |=> !match
  ) else $error("match repeated while equal");

  match_keep_a : assert property (
    match && ioc_q.act == ACT_KEEP && !ioc_upd_q |=> $stable(pin_out)
  ) else $error("retained pin moved on match");

  rise_only_a : assert property (
    ioc_q.capture && ioc_q.act == ACT_KEEP && $fell(pin_in) |-> !cap_pulse
  ) else $error("falling edge captured in rising mode");

  fall_only_a : assert property (
    ioc_q.capture && ioc_q.act == ACT_LOW && $rose(pin_in) |-> !cap_pulse
  ) else $error("rising edge captured in falling mode");

  udf_gate_a : assert property (
    !en_q[EN_UDF_BIT] |-> !udf_irq_out
  ) else $error("underflow request not gated");

  udf_flag_a : assert property (
    evt_in.underflow |=> st_q[EN_UDF_BIT] == ST_MASK[EN_UDF_BIT]
  ) else $error("underflow flag not set");

  ovf_flag_a : assert property (
    evt_in.overflow |=> st_q[EN_OVF_BIT]
  ) else $error("overflow flag not set");

  ovf_clear_a : assert property (
    wr_st && pwdata_in[EN_OVF_BIT] && !evt_in.overflow |=> !st_q[EN_OVF_BIT]
  ) else $error("overflow flag not cleared");

  regd_gate_a : assert property (
    !en_q[EN_REGD_BIT] |-> !regd_irq_out
  ) else $error("register D request not gated");

  adc_idle_a : assert property (
    !comp_pwm_in || !evt_in.trough |=> !adc_start_out
  ) else $error("converter start without trough");

  adc_reserved_a : assert property (
    !EN_MASK[EN_ADC_BIT] |-> !adc_start_out
  ) else $error("converter start in channel without it");

endmodule : tcio_top

// ==== test/tcio_pin_model.sv ====
`timescale 1ns/1ps
module tcio_pin_model (
  input wire logic dev_level_in,
  input wire logic dev_oe_in,
  input wire logic ext_level_in,
  output logic pin_level_out
);
  // Device drive wins while enabled, else the far side drives
  assign pin_level_out = dev_oe_in ? dev_level_in : ext_level_in;
endmodule : tcio_pin_model

// ==== test/testbench.sv ====
`timescale 1ns/1ps
module testbench;
  import tcio_pkg::*;
  logic clk_in = 0;
  logic arst_n_in = 0;
  logic psel = 0, penable = 0, pwrite = 0, comp_pwm = 0, ext_level = 0, adc_seen = 0;
  logic [ADDR_W-1:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata;
  logic pready, pslverr, pin_in, pin_out, pin_oe, irq, udf_irq, ovf_irq, regd_irq, adc_start;
  logic [15:0] counter = '0, rnd = 16'h000B, a, b;
  logic [7:0] cm [5] = '{8'h80, 8'hC0, 8'h90, 8'hA0, 8'hB0};
  tcio_evt_t evt = '0;
  logic [32:0] exp_q [$];
  int err_total = 0, n_tests = 0;
  logic init, res;

  always #4 clk_in = ~clk_in;

  tcio_top uut (.clk_in(clk_in), .arst_n_in(arst_n_in), .psel_in(psel), .penable_in(penable),
    .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata), .pstrb_in(4'hF), .prdata_out(prdata),
    .pready_out(pready), .pslverr_out(pslverr), .counter_in(counter), .evt_in(evt),
    .comp_pwm_in(comp_pwm), .pin_in(pin_in), .pin_out(pin_out), .pin_oe_out(pin_oe), .irq_out(irq),
    .udf_irq_out(udf_irq), .ovf_irq_out(ovf_irq), .regd_irq_out(regd_irq), .adc_start_out(adc_start));
  tcio_pin_model pin_model (.dev_level_in(pin_out), .dev_oe_in(pin_oe), .ext_level_in(ext_level),
    .pin_level_out(pin_in));

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr

  task automatic chk(input string what, input logic [32:0] e, input logic [32:0] g);
    n_tests++;
    if (g !== e) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", what, e, g);
    end
  endtask : chk

  task automatic apb(input logic wr, input logic [11:0] ad, input logic [31:0] d);
    @(posedge clk_in);
    psel <= 1;
    penable <= 0;
    pwrite <= wr;
    paddr <= ad;
    pwdata <= d;
    @(posedge clk_in);
    penable <= 1;
    do begin
      @(posedge clk_in);
    end while (pready !== 1'b1);
    psel <= 0;
    penable <= 0;
  endtask : apb

  task automatic rd(input logic [11:0] ad, input logic [32:0] e);
    exp_q.push_back(e);
    apb(0, ad, 0);
  endtask : rd

  task automatic see(input int k);
    repeat (k) @(posedge clk_in);
    #1;
  endtask : see

  task automatic pulse(input tcio_evt_t e);
    @(posedge clk_in) evt <= e;
    @(posedge clk_in) evt <= '0;
    see(2);
  endtask : pulse

  task automatic end_of_test;
    $display("checks %0d, mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : end_of_test

  // Read results come off the queue in issue order
  always @(posedge clk_in) begin
    if (adc_start === 1'b1) adc_seen <= 1;
    if (psel && penable && pready === 1'b1 && !pwrite) begin
      if (exp_q.size() == 0) chk("unexpected_read", 0, 1);
      else chk("apb_read", exp_q.pop_front(), {pslverr, prdata});
    end
  end

  initial begin
    repeat (20000) @(posedge clk_in);
    err_total++;
    end_of_test();
  end

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  initial begin
    repeat (2) @(posedge clk_in);
    arst_n_in <= 1;
    see(1);
    chk("pin_out", 0, pin_out);
    chk("pin_oe", 1, pin_oe);
    rd(OFS_IOCTL, 0);
    rd(OFS_INTEN, 0);
    apb(1, OFS_INTEN, 32'h32);
    rd(OFS_INTEN, 33'h32);
    rd(12'h100, 33'h1_0000_0000);
    $display("register test done");
    apb(1, OFS_STAT, 32'hFF);
    for (int act = 1; act < 4; act++) begin
      init = (act != 2);
      res = (act == 1) ? 1'b0 : (act == 2) ? 1'b1 : ~init;
      rnd = lfsr(rnd);
      @(posedge clk_in) counter <= ~rnd;
      apb(1, OFS_REGB, {16'h0, rnd});
      apb(1, OFS_IOCTL, {24'h0, 1'b0, init, 2'(act), 4'h0});
      see(3);
      chk("pin_init", init, pin_out);
      @(posedge clk_in) counter <= rnd;
      see(2);
      chk("pin_match", res, pin_out);
      chk("irq_match", 1, irq);
      rd(OFS_STAT, 33'h2);
      apb(1, OFS_STAT, 32'hFF);
    end
    apb(1, OFS_IOCTL, 32'h40);
    see(3);
    chk("pin_keep", 0, pin_out);
    $display("compare test done");
    foreach (cm[i]) begin
      apb(1, OFS_IOCTL, {24'h0, cm[i]});
      apb(1, OFS_REGB, 0);
      rnd = lfsr(rnd);
      a = rnd;
      rnd = lfsr(rnd);
      b = rnd;
      @(posedge clk_in);
      counter <= a;
      ext_level <= 1;
      see(3);
      rd(OFS_REGB, 33'((cm[i][5] || !cm[i][4]) ? a : 16'h0));
      @(posedge clk_in);
      counter <= b;
      ext_level <= 0;
      see(3);
      rd(OFS_REGB, 33'((cm[i][5] || cm[i][4]) ? b : a));
      rd(OFS_STAT, 33'h2);
      apb(1, OFS_STAT, 32'hFF);
      chk("pin_oe", 0, pin_oe);
    end
    $display("capture test done");
    apb(1, OFS_INTEN, 32'h30);
    @(posedge clk_in) comp_pwm <= 1;
    pulse(4'b0100);
    chk("udf_irq", 1, udf_irq);
    chk("irq", 1, irq);
    apb(1, OFS_INTEN, 32'h10);
    see(1);
    chk("udf_irq", 0, udf_irq);
    chk("irq", 0, irq);
    pulse(4'b0010);
    chk("ovf_irq", 1, ovf_irq);
    rd(OFS_STAT, 33'h30);
    apb(1, OFS_STAT, 32'h10);
    see(1);
    chk("ovf_irq", 0, ovf_irq);
    rd(OFS_STAT, 33'h20);
    apb(1, OFS_INTEN, 32'h00);
    pulse(4'b1001);
    chk("regd_irq", 0, regd_irq);
    chk("adc_start", 0, adc_seen);
    $display("event test done");
    end_of_test();
  end
endmodule : testbench
